// File: shared/gx_cfg.svh
// Function
// - Power-on reset sets all registers, bus engine.
// - Input pin has both drivers off.
// - Output pin driven from its latch bit.
// - Input pin edge asserts interrupt low.
// - Interrupt clears on return or input read.
// - New changes after clearing re-assert interrupt.
// - Output pins, foreign transfers never touch interrupt.
// - Output-to-input switch may raise interrupt.
// - Interrupt pin is open drain.
// - Matching address acknowledged during ninth clock.
// - Device acks received bytes; master nacks last.
// - Address is 0111 plus three select pins.
// - Address LSB one reads, zero writes.
// - First write byte sets two-bit pointer.
// - Pointer persists until next command byte.
// - Input register shows pins; writes ignored.
// - Invert bits flip reported input; reset zero.
// - Latch reads return latch; reset all ones.
// - Direction one is input; reset all ones.
// - Write accepts any number of data bytes.
// - Reads return pointed register, sampled at ack.
`ifndef GX_CFG_SVH
`define GX_CFG_SVH
`define GX_NUM_PINS 8
`define GX_ADDR_FIXED 4'h7
`define GX_RW_READ 1'h1
`define GX_REG_INPUT 2'h0
`define GX_REG_LATCH 2'h1
`define GX_REG_INVERT 2'h2
`define GX_REG_DIR 2'h3
`define GX_LATCH_RST 8'hff
`define GX_INVERT_RST 8'h00
`define GX_DIR_RST 8'hff
`define GX_PIN_OUT_RST 1'h1
`define GX_PIN_OE_RST 1'h1
`define GX_ACK_SLOT 4'h8
`define GX_BIT_ONE 4'h1
`define GX_SETTLE 2'h3
`endif

// File: shared/gx_pkg.sv
`default_nettype none
package gx_pkg;
  // Byte engine states
  typedef enum logic [2:0] {
    gx_st_idle  = 3'h0,
    gx_st_addr  = 3'h1,
    gx_st_cmd   = 3'h2,
    gx_st_wdata = 3'h3,
    gx_st_rdata = 3'h4
  } gx_state_t;
  typedef logic [1:0] gx_reg_sel_t;
endpackage
`default_nettype wire

// File: shared/gx_bit_if.sv
`default_nettype none
interface gx_bit_if;
  logic bit_value;
  logic bit_toggle;
  modport link (output bit_value, output bit_toggle);
  modport core (input bit_value, input bit_toggle);
endinterface
`default_nettype wire

// File: hdl/gx_link_sampler.sv
`default_nettype none
module gx_link_sampler (
  input  wire logic scl_in,
  input  wire logic rst_b_in,
  input  wire logic sda_in,
  gx_bit_if.link    bits
);
  // Data bit taken on each rising bus clock; toggle flags a new bit.
  // Value holds a whole bus period, so the core may read it once the toggle has crossed.
  always_ff @(posedge scl_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      bits.bit_value  <= 1'h0;
      bits.bit_toggle <= 1'h0;
    end
    else
    begin
      bits.bit_value  <= sda_in;
      bits.bit_toggle <= ~bits.bit_toggle;
    end
  end
endmodule
`default_nettype wire

// File: hdl/gx_pin_bank.sv
`include "gx_cfg.svh"
`default_nettype none
module gx_pin_bank #(
  parameter int WIDTH = `GX_NUM_PINS
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic [WIDTH-1:0] pins_in,
  input  wire logic [WIDTH-1:0] drive_latch_bits,
  input  wire logic [WIDTH-1:0] direction_bits,
  output logic      [WIDTH-1:0] pins_sync_out,
  output logic      [WIDTH-1:0] pins_out,
  output logic      [WIDTH-1:0] oe_b_out
);
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_pin
    logic meta;
    // Two-stage synchroniser; the first stage feeds only the second
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
      if (!rst_b_in)
      begin
        meta             <= 1'h0;
        pins_sync_out[i] <= 1'h0;
      end
      else
      begin
        meta             <= pins_in[i];
        pins_sync_out[i] <= meta;
      end
    end
    // Driver stage: enable low only when the pin is an output
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
      if (!rst_b_in)
      begin
        pins_out[i] <= `GX_PIN_OUT_RST;
        oe_b_out[i] <= `GX_PIN_OE_RST;
      end
      else
      begin
        pins_out[i] <= drive_latch_bits[i];
        oe_b_out[i] <= direction_bits[i];
      end
    end
  end
endmodule
`default_nettype wire

// File: hdl/gx_expander_top.sv
`include "gx_cfg.svh"
`default_nettype none
module gx_expander_top (
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_b_out,
  input  wire logic [2:0] addr_select_pins_in,
  input  wire logic [7:0] port_pins_in,
  output logic      [7:0] port_pins_out,
  output logic      [7:0] port_oe_b_out,
  output logic            int_out,
  output logic            int_oe_b_out
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]          pin_drive_latch;
  logic [7:0]          input_invert_mask;
  logic [7:0]          pin_direction;
  logic [7:0]          int_ref;
  logic [7:0]          pins_s;
  logic [7:0]          tx_shift;
  logic [7:0]          rx_shift;
  logic [7:0]          read_word;
  logic [3:0]          bit_cnt;
  logic [1:0]          settle_cnt;
  logic                ref_ready;
  gx_pkg::gx_reg_sel_t ptr;
  gx_pkg::gx_state_t   state;
  logic                scl_m;
  logic                scl_s;
  logic                scl_d;
  logic                sda_m;
  logic                sda_s;
  logic                sda_d;
  logic                tog_m;
  logic                tog_s;
  logic                tog_d;
  logic [2:0]          addr_m;
  logic [2:0]          addr_s;
  logic                start_det;
  logic                stop_det;
  logic                scl_fall;
  logic                bit_evt;
  logic                ack_evt;
  logic                addr_hit;
  logic                rd_next;
  logic                pending;

  gx_bit_if bits ();

  // ----------------------------------------------------------------
  // Link-clock sampler and pin bank
  // ----------------------------------------------------------------
  gx_link_sampler u_sampler (
    .scl_in   (scl_in),
    .rst_b_in (rst_b_in),
    .sda_in   (sda_in),
    .bits     (bits.link)
  );

  gx_pin_bank #(
    .WIDTH (`GX_NUM_PINS)
  ) u_pins (
    .clk_in           (clk_in),
    .rst_b_in         (rst_b_in),
    .pins_in          (port_pins_in),
    .drive_latch_bits (pin_drive_latch),
    .direction_bits   (pin_direction),
    .pins_sync_out    (pins_s),
    .pins_out         (port_pins_out),
    .oe_b_out         (port_oe_b_out)
  );

  // ----------------------------------------------------------------
  // Synchronisers into the core clock
  // ----------------------------------------------------------------
  // Bus lines and toggle: two stages plus one history stage for edges
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      scl_m <= 1'h1;
      scl_s <= 1'h1;
      scl_d <= 1'h1;
      sda_m <= 1'h1;
      sda_s <= 1'h1;
      sda_d <= 1'h1;
      tog_m <= 1'h0;
      tog_s <= 1'h0;
      tog_d <= 1'h0;
    end
    else
    begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
      tog_m <= bits.bit_toggle;
      tog_s <= tog_m;
      tog_d <= tog_s;
    end
  end

  // Select pins; assumed steady across a transfer
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      addr_m <= 3'h0;
      addr_s <= 3'h0;
    end
    else
    begin
      addr_m <= addr_select_pins_in;
      addr_s <= addr_m;
    end
  end

  // ----------------------------------------------------------------
  // Bus events
  // ----------------------------------------------------------------
  // Start and stop are data edges while the clock stays high
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;
  assign scl_fall  = scl_d & ~scl_s;
  assign bit_evt   = tog_s ^ tog_d;
  assign ack_evt   = bit_evt && (bit_cnt == `GX_ACK_SLOT) && (state != gx_pkg::gx_st_idle);
  assign addr_hit  = rx_shift[7:1] == {`GX_ADDR_FIXED, addr_s};
  // Next read byte follows an address-read ack or a master ack
  assign rd_next   = ack_evt && (((state == gx_pkg::gx_st_addr) && addr_hit
                     && (rx_shift[0] == `GX_RW_READ))
                     || ((state == gx_pkg::gx_st_rdata) && !bits.bit_value));

  // Register selected by the pointer
  always_comb
  begin
    case (ptr)
      `GX_REG_INPUT:  read_word = pins_s ^ input_invert_mask;
      `GX_REG_LATCH:  read_word = pin_drive_latch;
      `GX_REG_INVERT: read_word = input_invert_mask;
      default:        read_word = pin_direction;
    endcase
  end

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  // Start wins over everything, so a repeated start re-enters addressing
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state    <= gx_pkg::gx_st_idle;
      bit_cnt  <= 4'h0;
      rx_shift <= 8'h00;
    end
    else if (start_det)
    begin
      state   <= gx_pkg::gx_st_addr;
      bit_cnt <= 4'h0;
    end
    else if (stop_det)
    begin
      state   <= gx_pkg::gx_st_idle;
      bit_cnt <= 4'h0;
    end
    else if (bit_evt && (state != gx_pkg::gx_st_idle))
    begin
      if (bit_cnt != `GX_ACK_SLOT)
      begin
        rx_shift <= {rx_shift[6:0], bits.bit_value};
        bit_cnt  <= bit_cnt + `GX_BIT_ONE;
      end
      else
      begin
        bit_cnt <= 4'h0;
        case (state)
          gx_pkg::gx_st_addr:
          begin
            // Foreign address: sleep until the next start
            if (!addr_hit)
              state <= gx_pkg::gx_st_idle;
            else if (rx_shift[0] == `GX_RW_READ)
              state <= gx_pkg::gx_st_rdata;
            else
              state <= gx_pkg::gx_st_cmd;
          end
          gx_pkg::gx_st_cmd:   state <= gx_pkg::gx_st_wdata;
          gx_pkg::gx_st_wdata: state <= gx_pkg::gx_st_wdata;
          gx_pkg::gx_st_rdata:
          begin
            // Master nack ends the read; release and wait for stop
            state <= bits.bit_value ? gx_pkg::gx_st_idle : gx_pkg::gx_st_rdata;
          end
          default: state <= gx_pkg::gx_st_idle;
        endcase
      end
    end
  end

  // Pointer: only the command byte moves it, never auto-increments
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      ptr <= `GX_REG_INPUT;
    else if (ack_evt && (state == gx_pkg::gx_st_cmd))
      ptr <= rx_shift[1:0];
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Every data byte lands in the pointed register; input writes drop
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pin_drive_latch   <= `GX_LATCH_RST;
      input_invert_mask <= `GX_INVERT_RST;
      pin_direction     <= `GX_DIR_RST;
    end
    else if (ack_evt && (state == gx_pkg::gx_st_wdata))
    begin
      case (ptr)
        `GX_REG_LATCH:  pin_drive_latch   <= rx_shift;
        `GX_REG_INVERT: input_invert_mask <= rx_shift;
        `GX_REG_DIR:    pin_direction     <= rx_shift;
        default:        pin_drive_latch   <= pin_drive_latch;
      endcase
    end
  end

  // Transmit byte loaded at the ack clock, shifted per data bit
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      tx_shift <= 8'h00;
    else if (rd_next)
      tx_shift <= read_word;
    else if (bit_evt && (state == gx_pkg::gx_st_rdata) && (bit_cnt != `GX_ACK_SLOT))
      tx_shift <= {tx_shift[6:0], 1'h0};
  end

  // ----------------------------------------------------------------
  // Data line driver
  // ----------------------------------------------------------------
  // Drives low only after a falling clock so the line is stable while high; start and stop release it
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      sda_oe_b_out <= 1'h1;
    else if (start_det || stop_det)
      sda_oe_b_out <= 1'h1;
    else if (scl_fall)
    begin
      if ((state == gx_pkg::gx_st_addr) && (bit_cnt == `GX_ACK_SLOT) && addr_hit)
        sda_oe_b_out <= 1'h0;
      else if (((state == gx_pkg::gx_st_cmd) || (state == gx_pkg::gx_st_wdata))
               && (bit_cnt == `GX_ACK_SLOT))
        sda_oe_b_out <= 1'h0;
      else if ((state == gx_pkg::gx_st_rdata) && (bit_cnt != `GX_ACK_SLOT))
        sda_oe_b_out <= tx_shift[7];
      else
        sda_oe_b_out <= 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // Change detect
  // ----------------------------------------------------------------
  // Reference of pin levels; pending while any input pin differs from it.
  // Output pins are masked, so they never raise it; switching a pin back
  // to input with a new level does raise it.
  assign pending = |((pins_s ^ int_ref) & pin_direction);

  // Reference is caught after the synchroniser has filled, then only on
  // the ack of an input read; foreign reads never reach here.
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      int_ref    <= 8'h00;
      ref_ready  <= 1'h0;
      settle_cnt <= 2'h0;
    end
    else if (!ref_ready)
    begin
      settle_cnt <= settle_cnt + 2'h1;
      if (settle_cnt == `GX_SETTLE)
      begin
        int_ref   <= pins_s;
        ref_ready <= 1'h1;
      end
    end
    else if (ack_evt && (state == gx_pkg::gx_st_rdata) && (ptr == `GX_REG_INPUT))
      int_ref <= pins_s;
  end

  // Open-drain outputs: level always low, enable carries the state
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      int_out      <= 1'h0;
      sda_out      <= 1'h0;
      int_oe_b_out <= 1'h1;
    end
    else
    begin
      int_out      <= 1'h0;
      sda_out      <= 1'h0;
      int_oe_b_out <= ~(pending && ref_ready);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  a_int_has_cause: assert property (!int_oe_b_out |-> $past(pending))
    else $error("interrupt low without a pin mismatch");
  a_outputs_quiet: assert property ((pin_direction == 8'h00)[*2] |=> int_oe_b_out)
    else $error("output pins raised the interrupt");
  a_read_clears: assert property (
    ack_evt && (state == gx_pkg::gx_st_rdata) && (ptr == `GX_REG_INPUT)
    |=> (int_ref == $past(pins_s)))
    else $error("input read did not reload the reference");
  a_ptr_holds: assert property (
    !(ack_evt && (state == gx_pkg::gx_st_cmd)) |=> $stable(ptr))
    else $error("pointer moved without a command byte");
  a_input_ro: assert property (
    ack_evt && (state == gx_pkg::gx_st_wdata) && (ptr == `GX_REG_INPUT)
    |=> $stable(pin_drive_latch) && $stable(input_invert_mask)
        && $stable(pin_direction))
    else $error("write to input register changed state");
  a_addr_ack: assert property (
    scl_fall && !start_det && !stop_det && (state == gx_pkg::gx_st_addr)
    && (bit_cnt == `GX_ACK_SLOT) && addr_hit |=> !sda_oe_b_out)
    else $error("matching address not acknowledged");
  a_foreign_idle: assert property (
    ack_evt && !start_det && !stop_det && (state == gx_pkg::gx_st_addr) && !addr_hit
    |=> (state == gx_pkg::gx_st_idle) ##1 sda_oe_b_out)
    else $error("foreign address not ignored");
  a_read_mux: assert property (
    rd_next && !start_det && !stop_det && (ptr == `GX_REG_LATCH)
    |=> (tx_shift == $past(pin_drive_latch)))
    else $error("read byte not from pointed register");
  a_dir_write: assert property (
    ack_evt && !start_det && !stop_det && (state == gx_pkg::gx_st_wdata)
    && (ptr == `GX_REG_DIR)
    |=> (pin_direction == $past(rx_shift)) ##1 (port_oe_b_out == pin_direction))
    else $error("direction write did not reach the pins");
  a_stop_release: assert property (stop_det |=> sda_oe_b_out)
    else $error("data line held after stop");

  c_input_read: cover property (ack_evt && (state == gx_pkg::gx_st_rdata)
                                && (ptr == `GX_REG_INPUT));
  c_dir_write:  cover property (ack_evt && (state == gx_pkg::gx_st_wdata)
                                && (ptr == `GX_REG_DIR));
  c_foreign:    cover property (ack_evt && (state == gx_pkg::gx_st_addr) && !addr_hit);
  c_int_fires:  cover property (int_oe_b_out ##1 !int_oe_b_out);
endmodule
`default_nettype wire

// File: bench/gx_bus_master.sv
`default_nettype none
module gx_bus_master (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output var logic  scl_out,
  output var logic  sda_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // Bus timing
  // ----------------------------------------
  // A quarter bit in core cycles; SCL high and low last two quarters, but the low after a start lasts one,
  // which keeps every other phase at the 24-cycle minimum the device needs
  localparam int QTR = 12;

  // Idle bus: both lines released, SCL stands still between frames
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  // All line changes land just after a falling core clock edge
  task automatic qtr();
    repeat (QTR) @(negedge clk_in);
  endtask

  // Start or repeated start: SDA falls while SCL is high
  task automatic start();
    sda_out = 1'b1;
    qtr();
    scl_out = 1'b1;
    qtr();
    sda_out = 1'b0;
    qtr();
    scl_out = 1'b0;
  endtask

  // Stop: SDA rises while SCL is high
  task automatic stop();
    sda_out = 1'b0;
    qtr();
    scl_out = 1'b1;
    qtr();
    sda_out = 1'b1;
    qtr();
  endtask

  // One bit: set in the low phase, sampled in the middle of the high phase
  task automatic bit_io(input logic b, output logic s);
    sda_out = b;
    qtr();
    scl_out = 1'b1;
    qtr();
    s = sda_in;
    qtr();
    scl_out = 1'b0;
    qtr();
  endtask

  // Eight bits MSB first, then the ninth clock; 1 releases SDA
  task automatic xfer(input logic [7:0] tx, input logic ack_bit,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ack_bit, ack);
  endtask
endmodule
`default_nettype wire

// File: bench/i2c_eight_bit_io_expander_test.sv
`default_nettype none
module i2c_eight_bit_io_expander_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk_in   = 1'b0;
  logic       rst_b_in = 1'b0;
  logic [2:0] asel     = 3'h0;
  logic [7:0] ext      = 8'h00;
  logic [7:0] latch    = 8'hff;
  logic [7:0] inv      = 8'h00;
  logic [7:0] dir      = 8'hff;
  logic       scl;
  logic       m_sda;
  logic       sda;
  logic       sda_out;
  logic       sda_oe_b;
  logic       int_out;
  logic       int_oe_b;
  logic       int_n;
  logic       ack;
  logic [7:0] p_out;
  logic [7:0] p_oe_b;
  logic [7:0] pins;
  logic [7:0] rx0;
  logic [7:0] rx1;
  int         n_mismatch      = 0;
  int         samples_checked = 0;

  always #12.5 clk_in = ~clk_in;

  // ----------------------------------------
  // Wired lines
  // ----------------------------------------
  // SDA and the interrupt line have pull-ups; pins follow whoever drives
  assign sda   = m_sda & (sda_oe_b | sda_out);
  assign int_n = int_oe_b ? 1'b1 : int_out;
  assign pins  = (p_oe_b & ext) | (~p_oe_b & p_out);

  gx_bus_master u_master (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_out(m_sda));

  gx_expander_top u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_b_out(sda_oe_b),
    .addr_select_pins_in(asel), .port_pins_in(pins), .port_pins_out(p_out),
    .port_oe_b_out(p_oe_b), .int_out(int_out), .int_oe_b_out(int_oe_b));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One-bit results: acknowledge, line release, interrupt level
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Input register as seen through the inversion mask
  function automatic logic [7:0] exp_in();
    return ((dir & ext) | (~dir & latch)) ^ inv;
  endfunction

  function automatic logic [7:0] adr(input logic rd);
    return {4'h7, asel, rd};
  endfunction

  task automatic wbyte(input logic [7:0] b, input logic exp_ack);
    u_master.xfer(b, 1'b1, rx0, ack);
    chk_bit(ack, ~exp_ack);
  endtask

  // Earlier bytes differ from the last, so only the last may stick
  task automatic reg_wr(input logic [7:0] p, input logic [7:0] d, input int n);
    u_master.start();
    wbyte(adr(1'b0), 1'b1);
    wbyte(p, 1'b1);
    repeat (n - 1) wbyte(d ^ 8'h5a, 1'b1);
    wbyte(d, 1'b1);
    u_master.stop();
    case (p[1:0])
      2'h1: latch = d;
      2'h2: inv = d;
      2'h3: dir = d;
      default: ;
    endcase
  endtask

  // Two bytes read, acked then nacked; fresh sets the pointer first
  task automatic reg_rd(input logic [7:0] p, input logic fresh, input logic [7:0] exp);
    u_master.start();
    if (fresh)
    begin
      wbyte(adr(1'b0), 1'b1);
      wbyte(p, 1'b1);
      u_master.start();
    end
    wbyte(adr(1'b1), 1'b1);
    u_master.xfer(8'hff, 1'b0, rx0, ack);
    u_master.xfer(8'hff, 1'b1, rx1, ack);
    u_master.stop();
    chk(rx0, exp);
    chk(rx1, exp);
  endtask

  // Address byte meant for some other slave; nobody answers
  task automatic foreign(input logic [3:0] hi, input logic rd);
    u_master.start();
    wbyte({hi, asel, rd}, 1'b0);
    u_master.stop();
  endtask

  task automatic int_is(input logic e);
    wait_clk(12);
    chk_bit(int_n, e);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'hf2d4));
    wait_clk(16);
    chk(p_oe_b, 8'hff);
    chk_bit(int_n, 1'b1);
    rst_b_in = 1'b1;
    wait_clk(12);
    reg_rd(8'h01, 1'b1, 8'hff);
    reg_rd(8'h02, 1'b1, 8'h00);
    reg_rd(8'h03, 1'b1, 8'hff);
    reg_rd(8'h03, 1'b0, 8'hff);
    chk_bit(sda_oe_b, 1'b1);
    $display("test reset_values done");
    // Every select code, each followed by a stranger's address
    for (int a = 0; a < 8; a++)
    begin
      asel = 3'(a);
      u_master.start();
      wbyte(adr(1'b0), 1'b1);
      u_master.stop();
      foreign((a % 2) ? 4'hf : 4'h6, 1'b0);
    end
    asel = 3'($urandom());
    $display("test address done");
    // Random register traffic; upper pointer bits must be ignored
    for (int i = 0; i < 4; i++)
    begin
      ext = 8'($urandom());
      reg_wr(8'h01, 8'($urandom()), i + 1);
      reg_wr(8'hfe, 8'($urandom()), 1);
      reg_wr(8'h03, 8'($urandom()), 2);
      wait_clk(4);
      chk(p_oe_b, dir);
      chk(p_out & ~dir, latch & ~dir);
      reg_rd(8'h01, 1'b1, latch);
      reg_rd(8'h00, 1'b1, exp_in());
    end
    reg_wr(8'h00, 8'h3c, 2);
    reg_rd(8'h00, 1'b0, exp_in());
    $display("test registers done");
    // Interrupt: raise, return, raise, foreign read, clear by read, re-raise
    reg_wr(8'h03, 8'hff, 1);
    reg_rd(8'h00, 1'b1, exp_in());
    int_is(1'b1);
    ext[2] = ~ext[2];
    int_is(1'b0);
    ext[2] = ~ext[2];
    int_is(1'b1);
    ext[5] = ~ext[5];
    int_is(1'b0);
    foreign(4'h3, 1'b1);
    int_is(1'b0);
    reg_rd(8'h00, 1'b0, exp_in());
    int_is(1'b1);
    ext[6] = ~ext[6];
    int_is(1'b0);
    chk_bit(int_out, 1'b0);
    reg_wr(8'h03, 8'hfe, 1);
    reg_rd(8'h00, 1'b1, exp_in());
    int_is(1'b1);
    reg_wr(8'h01, latch ^ 8'h01, 1);
    int_is(1'b1);
    ext[0] = ~ext[0];
    int_is(1'b1);
    // All outputs: no pin may raise it; back to inputs at new levels may
    reg_wr(8'h03, 8'h00, 1);
    ext = ~ext;
    int_is(1'b1);
    reg_wr(8'h03, 8'hff, 1);
    int_is(1'b0);
    $display("test interrupt done");
    // Mid-run reset must bring back every default, pointer included
    rst_b_in = 1'b0;
    latch    = 8'hff;
    inv      = 8'h00;
    dir      = 8'hff;
    wait_clk(16);
    chk(p_out, latch);
    rst_b_in = 1'b1;
    int_is(1'b1);
    reg_rd(8'h00, 1'b0, exp_in());
    reg_rd(8'h01, 1'b1, latch);
    $display("test reset_again done");
    close_out();
  end

  // Hang guard: a run this long means a handshake never came
  initial
  begin
    repeat (100000) @(posedge clk_in);
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
